/* pcf_defs.vh */
// Constants for the point cloud payload framer
`ifndef PCF_DEFS_VH
`define PCF_DEFS_VH

// ----------------------------------------------------------------
// Fixed header bytes
// ----------------------------------------------------------------
`define PCF_SOP0        8'hee
`define PCF_SOP1        8'hff
`define PCF_VER_MAJ     8'h06
`define PCF_VER_MIN     8'h01
`define PCF_CH_NUM      8'h10
`define PCF_BLK_NUM     8'h08
`define PCF_DIS_UNIT    8'h04
`define PCF_RET_MAX     8'h02

// ----------------------------------------------------------------
// Packet geometry, in bytes and blocks
// ----------------------------------------------------------------
`define PCF_HDR_LAST    5'd11
`define PCF_ANG_LEN     7'd2
`define PCF_ENT_LEN     7'd4
`define PCF_BLK_LAST    7'd65
`define PCF_BLK_CNT_MAX 3'd7
`define PCF_TAIL_LAST   5'd23
`define PCF_SEQ_LAST    5'd27

// ----------------------------------------------------------------
// Header and tail byte offsets
// ----------------------------------------------------------------
`define PCF_H_CH        5'd6
`define PCF_H_BLK       5'd7
`define PCF_H_FIRST     5'd8
`define PCF_H_DIS       5'd9
`define PCF_H_RET       5'd10
`define PCF_H_SEQ       5'd11
`define PCF_T_MODE      5'd10
`define PCF_T_MOTOR     5'd11
`define PCF_T_DATE      5'd13
`define PCF_T_USEC      5'd19
`define PCF_T_FACT      5'd23
`define PCF_T_SEQ       5'd24

// ----------------------------------------------------------------
// Echo selection codes
// ----------------------------------------------------------------
`define PCF_M_FIRST     8'h33
`define PCF_M_STRONG    8'h37
`define PCF_M_LAST      8'h38
`define PCF_M_LS        8'h39
`define PCF_M_LF        8'h3b
`define PCF_M_FS        8'h3c

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define PCF_A_CTRL      8'h00
`define PCF_A_MOTOR     8'h04
`define PCF_A_DATE      8'h08
`define PCF_A_TIME      8'h0c
`define PCF_A_USEC      8'h10
`define PCF_A_STAT      8'h14
`define PCF_A_SEQ       8'h18
`define PCF_C_EN        0
`define PCF_C_SEQ       1
`define PCF_C_MODE_LO   8
`define PCF_C_MODE_HI   15

// ----------------------------------------------------------------
// Reset values and legal ranges
// ----------------------------------------------------------------
`define PCF_RST_MODE    8'h33
`define PCF_RST_MOTOR   16'h0258
`define PCF_RST_YEAR    8'h46
`define PCF_RST_MONTH   8'h01
`define PCF_RST_DAY     8'h01
`define PCF_YEAR_MIN    8'h46
`define PCF_MONTH_MAX   8'h0c
`define PCF_DAY_MAX     8'h1f
`define PCF_HOUR_MAX    8'h17
`define PCF_MINSEC_MAX  8'h3b
`define PCF_USEC_MAX    32'h000f4240

`endif

/* pcf_echo_sel.v */
// Echo selection for single and paired blocks
`default_nettype none
`include "pcf_defs.vh"

module pcf_echo_sel (
	// Mode and echo count
	input  wire [7:0]  mode_i,
	input  wire [1:0]  cnt_i,
	// Candidate echoes, {intensity, range}
	input  wire [23:0] first_i,
	input  wire [23:0] last_i,
	input  wire [23:0] strong_i,
	input  wire [23:0] second_i,
	// Entries for first and second block of a pair
	output reg  [23:0] a_o,
	output reg  [23:0] b_o,
	output wire        dual_o
);

	// ----------------------------------------------------------------
	// Selection
	// ----------------------------------------------------------------

	// Paired modes only
	assign dual_o = (mode_i == `PCF_M_LS) || (mode_i == `PCF_M_LF) ||
		(mode_i == `PCF_M_FS); // R11

	// Equal words mean the same echo won both criteria
	always @* begin
		a_o = first_i;
		b_o = first_i;
		case (mode_i)
			`PCF_M_FIRST: begin
				a_o = first_i; // R15
			end
			`PCF_M_STRONG: begin
				a_o = strong_i; // R15
			end
			`PCF_M_LAST: begin
				a_o = last_i; // R15
			end
			`PCF_M_LS: begin
				a_o = last_i; // R12
				b_o = (last_i == strong_i) ? second_i : strong_i; // R12
			end
			`PCF_M_LF: begin
				a_o = last_i; // R13
				b_o = (cnt_i < 2'd2) ? last_i : first_i; // R13
			end
			`PCF_M_FS: begin
				a_o = first_i; // R14
				b_o = (first_i == strong_i) ? second_i : strong_i; // R14
			end
			default: begin
				a_o = first_i;
			end
		endcase
	end

endmodule // pcf_echo_sel
`default_nettype wire

/* pcf_hdr_tail.v */
// Header and tail byte lookup for the payload framer
`default_nettype none
`include "pcf_defs.vh"

module pcf_hdr_tail #(
	parameter [7:0] FACTORY_ID = 8'h5a // Arbitrary value
) (
	// Region and byte index
	input  wire        tail_i,
	input  wire [4:0]  idx_i,
	// Field values
	input  wire [7:0]  mode_i,
	input  wire        seq_en_i,
	input  wire [15:0] motor_i,
	input  wire [23:0] date_i,
	input  wire [23:0] time_i,
	input  wire [31:0] usec_i,
	input  wire [31:0] seq_i,
	// Selected byte
	output reg  [7:0]  byte_o
);

	// ----------------------------------------------------------------
	// Byte lookup, multi-byte fields low byte first
	// ----------------------------------------------------------------
	always @* begin
		byte_o = 8'h00;
		if (!tail_i) begin
			case (idx_i)
				5'd0:        byte_o = `PCF_SOP0; // R1
				5'd1:        byte_o = `PCF_SOP1; // R1
				5'd2:        byte_o = `PCF_VER_MAJ; // R1
				5'd3:        byte_o = `PCF_VER_MIN; // R1
				`PCF_H_CH:   byte_o = `PCF_CH_NUM; // R3
				`PCF_H_BLK:  byte_o = `PCF_BLK_NUM; // R3
				`PCF_H_DIS:  byte_o = `PCF_DIS_UNIT; // R9
				`PCF_H_RET:  byte_o = `PCF_RET_MAX; // R4
				`PCF_H_SEQ:  byte_o = {7'h00, seq_en_i}; // R5
				default:     byte_o = 8'h00;
			endcase
		end else begin
			case (idx_i)
				`PCF_T_MODE:          byte_o = mode_i; // R20
				`PCF_T_MOTOR:         byte_o = motor_i[7:0]; // R2
				`PCF_T_MOTOR + 5'd1:  byte_o = motor_i[15:8];
				`PCF_T_DATE:          byte_o = date_i[7:0]; // R17
				`PCF_T_DATE + 5'd1:   byte_o = date_i[15:8];
				`PCF_T_DATE + 5'd2:   byte_o = date_i[23:16];
				`PCF_T_DATE + 5'd3:   byte_o = time_i[7:0];
				`PCF_T_DATE + 5'd4:   byte_o = time_i[15:8];
				`PCF_T_DATE + 5'd5:   byte_o = time_i[23:16];
				`PCF_T_USEC:          byte_o = usec_i[7:0]; // R19
				`PCF_T_USEC + 5'd1:   byte_o = usec_i[15:8];
				`PCF_T_USEC + 5'd2:   byte_o = usec_i[23:16];
				`PCF_T_USEC + 5'd3:   byte_o = usec_i[31:24];
				`PCF_T_FACT:          byte_o = FACTORY_ID; // R20
				`PCF_T_SEQ:           byte_o = seq_i[7:0]; // R21
				`PCF_T_SEQ + 5'd1:    byte_o = seq_i[15:8];
				`PCF_T_SEQ + 5'd2:    byte_o = seq_i[23:16];
				`PCF_T_SEQ + 5'd3:    byte_o = seq_i[31:24];
				default:              byte_o = 8'h00;
			endcase
		end
	end

endmodule // pcf_hdr_tail
`default_nettype wire

/* pcf_framer.v */
// Point cloud payload framer: APB registers, packet sequencer, byte stream
`default_nettype none
`include "pcf_defs.vh"

// Function
// R1: Start bytes, version bytes, two reserved bytes
// R2: Multi-byte fields sent low byte first
// R3: Header holds channel 0x10, block 0x08
// R4: Header max echoes byte is 0x02
// R5: Sequence flag bit 0, rest reserved
// R6: Body of eight blocks, 528 bytes
// R7: Block is angle plus sixteen entries
// R8: Angle field in hundredths of degree
// R9: Entry starts with range; unit 0x04
// R10: Intensity byte then one reserved byte
// R11: Paired blocks share one angle
// R12: Mode 0x39 last then strongest
// R13: Mode 0x3B last then first
// R14: Mode 0x3C first then strongest
// R15: Single codes 0x33, 0x37, 0x38
// R16: Only six echo selection codes allowed
// R17: Tail date-time, year to second order
// R18: Date and time fields range checked
// R19: Microsecond field, up to 1000000
// R20: Tail order: reserved, mode, motor, time
// R21: Optional 32-bit sequence counter appended
module pcf_framer (
	// Clock and reset
	input  wire        clk_sys_i,
	input  wire        rst_i,
	// APB slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [7:0]  paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output wire        pready_o,
	output reg         pslverr_o,
	// Measurement input, one channel per transfer
	input  wire        ch_valid_i,
	output wire        ch_ready_o,
	input  wire [15:0] ch_angle_i,
	input  wire [1:0]  ch_cnt_i,
	input  wire [23:0] ch_first_i,
	input  wire [23:0] ch_last_i,
	input  wire [23:0] ch_strong_i,
	input  wire [23:0] ch_second_i,
	// Payload byte stream
	output reg         out_valid_o,
	input  wire        out_ready_i,
	output reg  [7:0]  out_data_o,
	output reg         out_sop_o,
	output reg         out_eop_o
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_HDR  = 2'd1;
	localparam [1:0] ST_BODY = 2'd2;
	localparam [1:0] ST_TAIL = 2'd3;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	reg         ctrl_en;
	reg         ctrl_seq;
	reg  [7:0]  ctrl_mode;
	reg  [15:0] motor;
	reg  [23:0] date;
	reg  [23:0] tod;
	reg  [31:0] usec;
	reg  [31:0] seq_cnt;
	reg  [1:0]  st;
	reg  [4:0]  idx;
	reg  [6:0]  bpos;
	reg  [2:0]  blk;
	reg  [15:0] ang;
	reg  [23:0] ent;
	reg  [7:0]  mode_q;
	reg         seq_q;
	reg  [23:0] b_mem [0:15];
	reg  [31:0] rd_word;
	reg         addr_ok;
	reg         wr_ok;
	reg  [7:0]  body_byte;
	reg  [7:0]  next_byte;
	wire        mode_ok;
	wire        date_ok;
	wire        time_ok;
	wire        usec_ok;
	wire        apb_setup;
	wire        apb_wr;
	wire [23:0] sel_a;
	wire [23:0] sel_b;
	wire        dual;
	wire        is_b;
	wire [6:0]  boff;
	wire        ent_start;
	wire [3:0]  ch_k;
	wire [23:0] ent_src;
	wire        adv;
	wire        need_in;
	wire        step;
	wire        last_pos;
	wire [7:0]  ht_byte;

	// ----------------------------------------------------------------
	// APB decode and value checks
	// ----------------------------------------------------------------

	// Zero wait state slave
	assign pready_o  = 1'b1;
	assign apb_setup = psel_i && !penable_i;
	assign apb_wr    = psel_i && penable_i && pwrite_i;

	// Only the six defined codes are accepted
	assign mode_ok = (pwdata_i[15:8] == `PCF_M_FIRST) || (pwdata_i[15:8] == `PCF_M_STRONG) ||
		(pwdata_i[15:8] == `PCF_M_LAST) || (pwdata_i[15:8] == `PCF_M_LS) ||
		(pwdata_i[15:8] == `PCF_M_LF) || (pwdata_i[15:8] == `PCF_M_FS); // R16

	// Out-of-range calendar values never reach the tail
	assign date_ok = (pwdata_i[7:0] >= `PCF_YEAR_MIN) && (pwdata_i[15:8] != 8'h00) &&
		(pwdata_i[15:8] <= `PCF_MONTH_MAX) && (pwdata_i[23:16] != 8'h00) &&
		(pwdata_i[23:16] <= `PCF_DAY_MAX); // R18
	assign time_ok = (pwdata_i[7:0] <= `PCF_HOUR_MAX) && (pwdata_i[15:8] <= `PCF_MINSEC_MAX) &&
		(pwdata_i[23:16] <= `PCF_MINSEC_MAX); // R18
	assign usec_ok = (pwdata_i <= `PCF_USEC_MAX); // R19

	// Read mux and write acceptance
	always @* begin
		rd_word = 32'h0000_0000;
		addr_ok = 1'b1;
		wr_ok   = 1'b1;
		case (paddr_i)
			`PCF_A_CTRL: begin
				rd_word = {16'h0000, ctrl_mode, 6'h00, ctrl_seq, ctrl_en};
				wr_ok   = mode_ok;
			end
			`PCF_A_MOTOR: begin
				rd_word = {16'h0000, motor};
			end
			`PCF_A_DATE: begin
				rd_word = {8'h00, date};
				wr_ok   = date_ok;
			end
			`PCF_A_TIME: begin
				rd_word = {8'h00, tod};
				wr_ok   = time_ok;
			end
			`PCF_A_USEC: begin
				rd_word = usec;
			end
			`PCF_A_STAT: begin
				rd_word = {21'h000000, blk, 7'h00, (st != ST_IDLE)};
			end
			`PCF_A_SEQ: begin
				rd_word = seq_cnt;
			end
			default: begin
				addr_ok = 1'b0;
				wr_ok   = 1'b0;
			end
		endcase
		if (`PCF_A_USEC == paddr_i) begin
			wr_ok = usec_ok;
		end
	end

	// ----------------------------------------------------------------
	// APB registers
	// ----------------------------------------------------------------

	// Answer latched at setup so access-phase data comes from flops
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
			ctrl_en   <= 1'b0;
			ctrl_seq  <= 1'b0;
			ctrl_mode <= `PCF_RST_MODE;
			motor     <= `PCF_RST_MOTOR;
			date      <= {`PCF_RST_DAY, `PCF_RST_MONTH, `PCF_RST_YEAR};
			tod       <= 24'h000000;
			usec      <= 32'h0000_0000;
		end else begin
			if (apb_setup) begin
				prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_word;
				pslverr_o <= !addr_ok || (pwrite_i && !wr_ok);
			end
			if (apb_wr && wr_ok) begin
				case (paddr_i)
					`PCF_A_CTRL: begin
						ctrl_en   <= pwdata_i[`PCF_C_EN];
						ctrl_seq  <= pwdata_i[`PCF_C_SEQ];
						ctrl_mode <= pwdata_i[`PCF_C_MODE_HI:`PCF_C_MODE_LO]; // R16
					end
					`PCF_A_MOTOR: motor <= pwdata_i[15:0];
					`PCF_A_DATE:  date  <= pwdata_i[23:0]; // R18
					`PCF_A_TIME:  tod   <= pwdata_i[23:0]; // R18
					`PCF_A_USEC:  usec  <= pwdata_i; // R19
					default: begin
						motor <= motor;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Echo selection and fixed fields
	// ----------------------------------------------------------------
	pcf_echo_sel u_sel (
		.mode_i   (mode_q),
		.cnt_i    (ch_cnt_i),
		.first_i  (ch_first_i),
		.last_i   (ch_last_i),
		.strong_i (ch_strong_i),
		.second_i (ch_second_i),
		.a_o      (sel_a),
		.b_o      (sel_b),
		.dual_o   (dual)
	);

	pcf_hdr_tail u_ht (
		.tail_i   (st == ST_TAIL),
		.idx_i    (idx),
		.mode_i   (mode_q),
		.seq_en_i (seq_q),
		.motor_i  (motor),
		.date_i   (date),
		.time_i   (tod),
		.usec_i   (usec),
		.seq_i    (seq_cnt),
		.byte_o   (ht_byte)
	);

	// ----------------------------------------------------------------
	// Body position decode
	// ----------------------------------------------------------------

	// Odd blocks replay the stored second-block entries in paired modes
	assign is_b      = dual && blk[0]; // R11
	assign boff      = bpos - `PCF_ANG_LEN;
	// Channel 0 is fetched with the angle so both bytes are on hand
	assign ent_start = (bpos == 7'd0) ||
		((bpos >= (`PCF_ANG_LEN + `PCF_ENT_LEN)) && (boff[1:0] == 2'b00)); // R7
	assign ch_k      = (bpos == 7'd0) ? 4'd0 : boff[5:2]; // R6
	assign ent_src   = is_b ? b_mem[ch_k] : sel_a;

	// Output register free, and input present when the byte needs it
	assign adv        = !out_valid_o || out_ready_i;
	assign need_in    = (st == ST_BODY) && ent_start && !is_b;
	assign step       = adv && (st != ST_IDLE) && (!need_in || ch_valid_i);
	assign ch_ready_o = adv && need_in;
	assign last_pos   = (idx == (seq_q ? `PCF_SEQ_LAST : `PCF_TAIL_LAST));

	// Body byte: angle, then range, intensity, reserved per entry
	always @* begin
		body_byte = 8'h00;
		if (bpos == 7'd0) begin
			body_byte = is_b ? ang[7:0] : ch_angle_i[7:0]; // R8
		end else if (bpos == 7'd1) begin
			body_byte = ang[15:8]; // R2
		end else begin
			case (boff[1:0])
				2'd0:    body_byte = ent_start ? ent_src[7:0] : ent[7:0]; // R9
				2'd1:    body_byte = ent[15:8]; // R9
				2'd2:    body_byte = ent[23:16]; // R10
				default: body_byte = 8'h00; // R10
			endcase
		end
		next_byte = (st == ST_BODY) ? body_byte : ht_byte;
	end

	// ----------------------------------------------------------------
	// Packet sequencer
	// ----------------------------------------------------------------

	// Mode and sequence flag frozen per packet so pairs stay consistent
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			st          <= ST_IDLE;
			idx         <= 5'd0;
			bpos        <= 7'd0;
			blk         <= 3'd0;
			ang         <= 16'h0000;
			ent         <= 24'h000000;
			mode_q      <= `PCF_RST_MODE;
			seq_q       <= 1'b0;
			seq_cnt     <= 32'h0000_0000;
			out_valid_o <= 1'b0;
			out_data_o  <= 8'h00;
			out_sop_o   <= 1'b0;
			out_eop_o   <= 1'b0;
		end else begin
			if (adv) begin
				out_valid_o <= step;
			end
			if (step) begin
				out_data_o <= next_byte;
				out_sop_o  <= (st == ST_HDR) && (idx == 5'd0);
				out_eop_o  <= (st == ST_TAIL) && last_pos;
			end
			case (st)
				ST_IDLE: begin
					if (ctrl_en) begin
						mode_q <= ctrl_mode;
						seq_q  <= ctrl_seq; // R5
						idx    <= 5'd0;
						st     <= ST_HDR;
					end
				end
				ST_HDR: begin
					if (step) begin
						idx <= idx + 5'd1;
						if (idx == `PCF_HDR_LAST) begin
							bpos <= 7'd0;
							blk  <= 3'd0;
							st   <= ST_BODY;
						end
					end
				end
				ST_BODY: begin
					if (step) begin
						if ((bpos == 7'd0) && !is_b) begin
							ang <= ch_angle_i; // R11
						end
						if (ent_start) begin
							ent <= ent_src; // R9
						end
						bpos <= bpos + 7'd1;
						if (bpos == `PCF_BLK_LAST) begin
							bpos <= 7'd0;
							blk  <= blk + 3'd1; // R6
							if (blk == `PCF_BLK_CNT_MAX) begin
								idx <= 5'd0;
								st  <= ST_TAIL;
							end
						end
					end
				end
				ST_TAIL: begin
					if (step) begin
						idx <= idx + 5'd1;
						if (last_pos) begin
							st <= ST_IDLE;
							if (seq_q) begin
								seq_cnt <= seq_cnt + 32'h0000_0001; // R21
							end
						end
					end
				end
				default: begin
					st <= ST_IDLE;
				end
			endcase
		end
	end

	// Second-block entries parked while the first block goes out
	always @(posedge clk_sys_i) begin
		if (step && need_in && dual) begin
			b_mem[ch_k] <= sel_b; // R11
		end
	end

endmodule // pcf_framer
`default_nettype wire

/* pcf_framer_properties.sv */
// Port checker for the point cloud payload framer
`default_nettype none
module pcf_framer_properties (
	// Clock and reset
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	// APB side
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pslverr_o,
	// Channel and stream side
	input wire logic        ch_valid_i,
	input wire logic        ch_ready_o,
	input wire logic        out_valid_o,
	input wire logic        out_ready_i,
	input wire logic [7:0]  out_data_o,
	input wire logic        out_sop_o,
	input wire logic        out_eop_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------
	// Byte position tracking
	// ------------------------------------------------
	logic [15:0] idx;
	wire take = out_valid_o && out_ready_i;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// Index of the byte on show; only meaningful when sop is low
	always @(posedge clk_sys_i) begin
		if (rst_i)
			idx <= 16'h0;
		else if (take)
			idx <= out_sop_o ? 16'h1 : idx + 16'h1;
	end
	sequence setup_s;
		psel_i && !penable_i;
	endsequence
	sequence sop_taken_s;
		take && out_sop_o && out_data_o == 8'hee;
	endsequence
	chk_unmapped_err: assert property (setup_s ##0 paddr_i > 8'h18 |=>
		pslverr_o && prdata_o == 32'h0) else $error("unmapped access not refused");
	chk_bad_mode: assert property (setup_s ##0 (pwrite_i && paddr_i == 8'h00 &&
		!(pwdata_i[15:8] inside {8'h33, 8'h37, 8'h38, 8'h39, 8'h3b, 8'h3c})) |=> pslverr_o)
		else $error("illegal mode write accepted");
	chk_sop_start: assert property (out_valid_o && out_sop_o |-> out_data_o == 8'hee)
		else $error("packet does not open with start byte");
	chk_second_start: assert property (sop_taken_s |=>
		out_valid_o && !out_sop_o && out_data_o == 8'hff) else $error("second start byte");
	chk_byte_hold: assert property (out_valid_o && !out_ready_i |=>
		out_valid_o && $stable(out_data_o) && $stable(out_eop_o)) else $error("byte dropped");
	chk_hdr_counts: assert property (take && !out_sop_o |->
		(idx != 16'd6 || out_data_o == 8'h10) && (idx != 16'd7 || out_data_o == 8'h08))
		else $error("channel or block count byte");
	chk_echo_max: assert property (take && !out_sop_o && idx == 16'd10 |->
		out_data_o == 8'h02) else $error("max echo byte");
	chk_flag_rsvd: assert property (take && !out_sop_o && idx == 16'd11 |->
		out_data_o[7:1] == 7'h0) else $error("flag byte reserved bits");
	chk_pkt_len: assert property (take && out_eop_o |-> !out_sop_o &&
		(idx == 16'd563 || idx == 16'd567)) else $error("packet length");
	// Idle follows the last byte step, so only a take on its first cycle forces a gap
	chk_eop_idle: assert property (take && $rose(out_eop_o) |=> !out_valid_o)
		else $error("no idle cycle after packet");
	chk_fetch_byte: assert property (ch_valid_i && ch_ready_o |=> out_valid_o)
		else $error("channel taken without byte step");
endmodule // pcf_framer_properties
bind pcf_framer pcf_framer_properties u_pcf_framer_properties (.clk_sys_i, .rst_i,
	.psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pslverr_o,
	.ch_valid_i, .ch_ready_o, .out_valid_o, .out_ready_i, .out_data_o, .out_sop_o,
	.out_eop_o);
`default_nettype wire

/* pcf_host_sink.sv */
// Host model that takes payload bytes and keeps the last packet
`default_nettype none
module pcf_host_sink (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// Pace: slow host takes one byte in four
	input  wire logic        stall_i,
	// Byte stream
	input  wire logic        valid_i,
	input  wire logic [7:0]  data_i,
	input  wire logic        sop_i,
	input  wire logic        eop_i,
	output var  logic        ready_o,
	// Capture status
	output var  logic [7:0]  npkt_o,
	output var  logic [15:0] last_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [0:567];
	logic [15:0] ptr;
	wire  [15:0] ix = sop_i ? 16'h0 : ptr;
	logic [1:0]  cyc;
	// Store by position; a missing start byte shows up as a shifted packet
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			ready_o <= 1'b0;
			npkt_o <= 8'h0;
			ptr <= 16'h0;
			cyc <= 2'h0;
		end else begin
			cyc <= cyc + 2'h1;
			ready_o <= !stall_i || cyc == 2'h0;
			if (valid_i && ready_o) begin
				mem[ix] <= data_i;
				ptr <= ix + 16'h1;
				if (eop_i) begin
					last_o <= ix;
					npkt_o <= npkt_o + 8'h1;
				end
			end
		end
	end
endmodule // pcf_host_sink
`default_nettype wire

/* tb_point_cloud_udp_payload_framer.sv */
// Self-checking bench for the point cloud payload framer
`default_nettype none
module tb_point_cloud_udp_payload_framer;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------
	// Signals and fixed echo data
	// ------------------------------------------------
	localparam logic [23:0] E_F = 24'h110102;
	localparam logic [23:0] E_L = 24'h220304;
	localparam logic [23:0] E_S2 = 24'h440708;
	localparam logic [7:0]  FACT = 8'h5a; // Arbitrary, same as the design default
	logic        clk_sys_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [7:0]  paddr_i = 8'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic        ch_valid_i = 1'b0;
	logic [15:0] ch_angle_i = 16'h0;
	logic        stall = 1'b0;
	logic        alt = 1'b0;
	logic [31:0] prdata_o;
	logic        pready_o, pslverr_o, ch_ready_o, out_ready_i;
	logic        out_valid_o, out_sop_o, out_eop_o;
	logic [7:0]  out_data_o, npkt;
	logic [15:0] last;
	logic [31:0] seqv = 32'h0;
	int          err_count = 0;
	int          n_compared = 0;
	logic [7:0]  modes [8] = '{8'h33, 8'h37, 8'h38, 8'h39, 8'h3b, 8'h3c, 8'h3b, 8'h3c};
	always #25 clk_sys_i = ~clk_sys_i;
	pcf_framer u_pcf_framer (.clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ch_valid_i, .ch_ready_o, .ch_angle_i,
		.ch_cnt_i(alt ? 2'd1 : 2'd3), .ch_first_i(E_F ^ {8'h0, ch_angle_i}),
		.ch_last_i(E_L ^ {8'h0, ch_angle_i}),
		.ch_strong_i((alt ? E_F : E_L) ^ {8'h0, ch_angle_i}),
		.ch_second_i(E_S2 ^ {8'h0, ch_angle_i}), .out_valid_o, .out_ready_i, .out_data_o,
		.out_sop_o, .out_eop_o);
	pcf_host_sink u_pcf_host_sink (.clk_sys_i, .rst_i, .stall_i(stall), .valid_i(out_valid_o),
		.data_i(out_data_o), .sop_i(out_sop_o), .eop_i(out_eop_o), .ready_o(out_ready_i),
		.npkt_o(npkt), .last_o(last));
	// Source gaps one cycle after each take; angle counts channels taken
	always @(posedge clk_sys_i) begin
		if (rst_i)
			ch_valid_i <= 1'b0;
		else begin
			ch_valid_i <= !(ch_valid_i && ch_ready_o);
			if (ch_valid_i && ch_ready_o)
				ch_angle_i <= ch_angle_i + 16'h1;
		end
	end
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	// One APB transfer, then an idle edge so the next request never lands in this step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do @(posedge clk_sys_i); while (pready_o !== 1'b1);
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk_bit(e, xe);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk_word(r, x);
		chk_bit(e, xe);
	endtask
	// Expected payload byte from position, mode and sequence flag
	function automatic logic [7:0] exp_b(input int i, input logic [7:0] m, input logic s,
			input logic [15:0] base);
		int b, o;
		logic [23:0] e;
		logic [15:0] an;
		logic [95:0] hd;
		logic [223:0] tl;
		hd = {7'h0, s, 8'h02, 8'h04, 8'h00, 8'h08, 8'h10, 16'h0, 8'h01, 8'h06, 8'hff, 8'hee};
		tl = {seqv, FACT, 32'h000f4240, 48'h3b3b171f0c7c, 16'h1234, m, 80'h0};
		b = (i - 12) / 66;
		o = (i - 12) % 66;
		an = base + 16'(16 * ((m > 8'h38) ? b / 2 : b));
		case (m)
			8'h33: e = E_F;
			8'h39: e = b[0] ? E_S2 : E_L;
			8'h3b: e = (b[0] && !alt) ? E_F : E_L;
			8'h3c: e = b[0] ? (alt ? E_S2 : E_L) : E_F;
			default: e = E_L;
		endcase
		if (i < 12) return hd[i*8 +: 8];
		if (i >= 540) return tl[(i-540)*8 +: 8];
		if (o < 2) return an[o*8 +: 8];
		// Echo words carry the live angle, so a stale or early fetch shows up
		e = e ^ {8'h0, an + 16'((o - 2) / 4)};
		o = (o - 2) % 4;
		return (o == 3) ? 8'h00 : e[o*8 +: 8];
	endfunction
	// Enable for exactly one packet, then compare it whole
	task automatic run_pkt(input logic [7:0] m, input logic s);
		logic [15:0] base;
		logic [7:0] np;
		base = ch_angle_i;
		np = npkt;
		wr(8'h00, {16'h0, m, 6'h0, s, 1'b1}, 1'b0);
		while (out_valid_o !== 1'b1) @(posedge clk_sys_i);
		wr(8'h00, {16'h0, m, 6'h0, s, 1'b0}, 1'b0);
		while (npkt === np) @(posedge clk_sys_i);
		for (int i = 0; i < (s ? 568 : 564); i++)
			chk_word(32'(u_pcf_host_sink.mem[i]), 32'(exp_b(i, m, s, base)));
		chk_word(32'(last), s ? 32'd567 : 32'd563);
		if (s)
			seqv = seqv + 32'h1;
		rd(8'h18, seqv, 1'b0);
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		rd(8'h00, 32'h00003300, 1'b0);
		rd(8'h04, 32'h00000258, 1'b0);
		rd(8'h08, 32'h00010146, 1'b0);
		rd(8'h1c, 32'h0, 1'b1);
		wr(8'h00, 32'h00003400, 1'b1);
		rd(8'h00, 32'h00003300, 1'b0);
		wr(8'h08, 32'h00010145, 1'b1);
		wr(8'h0c, 32'h00000018, 1'b1);
		wr(8'h10, 32'h000f4241, 1'b1);
		wr(8'h18, 32'h00000005, 1'b0);
		wr(8'h08, 32'h001f0c7c, 1'b0);
		wr(8'h0c, 32'h003b3b17, 1'b0);
		wr(8'h10, 32'h000f4240, 1'b0);
		wr(8'h04, 32'h00001234, 1'b0);
		for (int k = 0; k < 8; k++) begin
			stall <= k[0];
			alt <= (k >= 6);
			run_pkt(modes[k], k[1]);
		end
		print_verdict();
	end
	// Watchdog: slow packets need about 2300 cycles each
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		err_count++;
		print_verdict();
	end
endmodule // tb_point_cloud_udp_payload_framer
`default_nettype wire
